// ---- hdl/crtac_map.svh ----
// Purpose: Register indices, field positions, reset values and scale constants of the
//          capacity, rate, temperature and age compensation block.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef CRTAC_MAP_SVH
`define CRTAC_MAP_SVH

// Register indices (byte address = index * 4).
`define CRTAC_IDX_INIT_FULL_CAP 8'h76
`define CRTAC_IDX_EMPTY_SCALED 8'h77
`define CRTAC_IDX_WARN_SCALED 8'h78
`define CRTAC_IDX_THR_COLD_GAIN 8'h79
`define CRTAC_IDX_PACK_CONFIG 8'h7c
`define CRTAC_IDX_AGE_THR 8'h7d
`define CRTAC_IDX_RATE_COEFFS 8'h7e
`define CRTAC_IDX_COLD_COEFFS 8'h7f
`define CRTAC_IDX_UPD_RATE 8'h60
`define CRTAC_IDX_UPD_COLD 8'h61
`define CRTAC_IDX_LEARNED_CAP 8'h62
`define CRTAC_IDX_FULL_RESET 8'h63
`define CRTAC_IDX_STATUS 8'h64
`define CRTAC_IDX_AVAIL 8'h65
`define CRTAC_IDX_FULL 8'h66
`define CRTAC_IDX_WARN 8'h67
`define CRTAC_IDX_REDUCTION 8'h68

// Pack configuration bit positions and fixed coefficient bytes.
`define CRTAC_FIXED_RATE_BIT 1
`define CRTAC_FIXED_COLD_BIT 0
`define CRTAC_FIXED_RATE_COEFF 8'h6c
`define CRTAC_FIXED_COLD_COEFF 8'h46

// Reset values of the configuration bytes.
`define CRTAC_RST_BYTE 8'h00
`define CRTAC_RST_LEARNED 16'h0000

// Scale constants.
`define CRTAC_KELVIN_OFFSET 10'h111
`define CRTAC_AGE_UNITY 29'h200
`define CRTAC_TEMP_UNITY 16'h20
`define CRTAC_THR_UNITY 15'h80
`define CRTAC_MV_PER_COUNT 48'h8
`define CRTAC_SCALE_BIAS 13'h100
`define CRTAC_MV_SHIFT 3
`define CRTAC_EMPTY_MARGIN 13'h20
`define CRTAC_RED_SHIFT 22
`define CRTAC_OFF_SHIFT 3
`define CRTAC_DROP_SHIFT 15
`define CRTAC_DIV_LAST 6'h2f

`endif

// ---- hdl/crtac_pkg.sv ----
// Purpose: Types shared by the compensation block and its users.
// Assumes: Constants live in crtac_map.svh.
// Notes:   Types only.
`default_nettype none
package crtac_pkg;

  typedef enum logic [1:0] {
    CRTAC_IDLE,
    CRTAC_DIVIDE
  } crtac_fsm_type;

  typedef struct packed {
    logic [15:0] averageCurrent;
    logic [11:0] tempKelvin;
    logic [15:0] totalCycleCount;
    logic [15:0] nominalAvailableCharge;
  } crtac_meas_type;

  typedef struct packed {
    logic [15:0] availCharge;
    logic [15:0] fullCapacity;
    logic [15:0] warnThresholdMv;
    logic [15:0] reduction;
  } crtac_result_type;

  typedef struct packed {
    crtac_fsm_type fsm;
    logic [7:0] initFullCap;
    logic [7:0] emptyScaled;
    logic [7:0] warnScaled;
    logic [7:0] thrColdReg;
    logic [7:0] packConfig;
    logic [7:0] ageThrReg;
    logic [7:0] rateStored;
    logic [7:0] coldStored;
    logic [7:0] rateHost;
    logic [7:0] coldHost;
    logic rateHostOvr;
    logic coldHostOvr;
    logic fullResetPend;
    logic [15:0] learnedCap;
    crtac_meas_type meas;
    logic [15:0] reductionPend;
    logic [47:0] divNum;
    logic [7:0] divRem;
    logic [5:0] divCnt;
    crtac_result_type res;
    logic resultValid;
    logic nacToFull;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } crtac_state_type;

endpackage

`default_nettype wire

// ---- hdl/crtac_comp.sv ----
// Purpose: Rate, temperature and age compensation of available capacity, and rate and
//          temperature compensation of the low-voltage warning threshold, with an APB register file.
// Assumes: Measurement inputs come from logic on core_clk; averageCurrent is the
//          discharge magnitude; 1C equals the initial full capacity byte times 256.
// Notes:   One compensation pass per measurement update taken while idle, about 49 cycles long.
`timescale 1ns/100ps
`default_nettype none
`include "crtac_map.svh"

////////////////////////////////////////////////////////////////////////////////////////

module crtac_comp (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements from the gauge core
  input wire logic measUpdate,
  input wire crtac_pkg::crtac_meas_type measIn,
  input wire logic minimumTaperDetect,
  // Compensated results
  output crtac_pkg::crtac_result_type results,
  output logic resultValid,
  output logic [15:0] learnedFullCapacity,
  output logic nacToFullAllowed,
  output logic busy
);
  import crtac_pkg::*;

  // All state sits in one register so that reset and update stay in one place.
  crtac_state_type st_r;
  crtac_state_type st_nxt;

  //////////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // A host update wins over a fixed selection, which wins over the stored byte.
  // Under a set fixed bit the stored byte is free for the user; the compensation never uses it, but it still reads back over APB.
  function automatic logic [7:0] effCoeff(input logic hostOvr, input logic fixedSel,
                                          input logic [7:0] hostVal,
                                          input logic [7:0] fixedVal,
                                          input logic [7:0] stored);
    if (hostOvr) begin
      effCoeff = hostVal;
    end else if (fixedSel) begin
      effCoeff = fixedVal;
    end else begin
      effCoeff = stored;
    end
  endfunction

  // Only aligned indices below the first kilobyte are mapped; the rest answer with an error.
  function automatic logic isMapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    isMapped = 1'b0;
    if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) begin
      case (idx)
        `CRTAC_IDX_INIT_FULL_CAP, `CRTAC_IDX_EMPTY_SCALED, `CRTAC_IDX_WARN_SCALED,
        `CRTAC_IDX_THR_COLD_GAIN, `CRTAC_IDX_PACK_CONFIG, `CRTAC_IDX_AGE_THR,
        `CRTAC_IDX_RATE_COEFFS, `CRTAC_IDX_COLD_COEFFS, `CRTAC_IDX_UPD_RATE,
        `CRTAC_IDX_UPD_COLD, `CRTAC_IDX_LEARNED_CAP, `CRTAC_IDX_FULL_RESET,
        `CRTAC_IDX_STATUS, `CRTAC_IDX_AVAIL, `CRTAC_IDX_FULL, `CRTAC_IDX_WARN,
        `CRTAC_IDX_REDUCTION: isMapped = 1'b1;
        default: isMapped = 1'b0;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////
  // Coefficient selection and field extraction

  logic [7:0] rateByte;
  logic [7:0] coldByte;
  logic [4:0] rateGain;
  logic [2:0] rateOffCode;
  logic [4:0] coldGain;
  logic [2:0] coldOffCode;
  logic [1:0] ageFactor;
  logic [5:0] thresholdRateGain;
  logic [3:0] thresholdColdGain;

  assign rateByte = effCoeff(st_r.rateHostOvr, st_r.packConfig[`CRTAC_FIXED_RATE_BIT],
                             st_r.rateHost, `CRTAC_FIXED_RATE_COEFF, st_r.rateStored);
  assign coldByte = effCoeff(st_r.coldHostOvr, st_r.packConfig[`CRTAC_FIXED_COLD_BIT],
                             st_r.coldHost, `CRTAC_FIXED_COLD_COEFF, st_r.coldStored);
  assign rateGain = rateByte[7:3];
  assign rateOffCode = rateByte[2:0];
  assign coldGain = coldByte[7:3];
  assign coldOffCode = coldByte[2:0];
  // Age factor and threshold rate gain share one byte, the age factor on top.
  assign ageFactor = st_r.ageThrReg[7:6];
  assign thresholdRateGain = st_r.ageThrReg[5:0];
  assign thresholdColdGain = st_r.thrColdReg[3:0];

  //////////////////////////////////////////////////////////////////////////////////////
  // Cold threshold and capacity reduction, from the live measurement

  logic [9:0] coldThrKelvin;
  logic [11:0] coldDiff;
  logic coldBelow;
  logic [9:0] coldDeg;
  logic [22:0] agePart;
  logic [28:0] agedNum;
  logic [15:0] tempFactor;
  logic [63:0] reductionTerm;
  logic [15:0] offsetThr;
  logic [63:0] reductionDiff;
  logic [15:0] reductionNow;

  // Temperature arrives in kelvin, so the cold threshold is built on the freezing point.
  // The difference is only used when the cell is colder, so its wrap never matters.
  assign coldThrKelvin = `CRTAC_KELVIN_OFFSET + {6'h00, coldOffCode, 1'b0};
  assign coldBelow = {2'h0, coldThrKelvin} > measIn.tempKelvin;
  assign coldDiff = {2'h0, coldThrKelvin} - measIn.tempKelvin;
  assign coldDeg = coldBelow ? coldDiff[9:0] : 10'h000;

  // Unity 512 stands for 16 * 32, so a zero age factor leaves the gain untouched.
  assign agePart = 23'(coldGain) * 23'(measIn.totalCycleCount) * 23'(ageFactor);
  assign agedNum = 29'(rateGain) * (29'(agePart) + `CRTAC_AGE_UNITY);
  assign tempFactor = 16'(coldGain) * 16'(coldDeg) + `CRTAC_TEMP_UNITY;
  // Shifting by 22 folds the gain scale of 256, the age unity and the cold unity.
  // Products stay wide so that the saturation below sees the true value.
  assign reductionTerm = (64'(measIn.averageCurrent) * 64'(agedNum) * 64'(tempFactor))
                         >> `CRTAC_RED_SHIFT;
  assign offsetThr = 16'((16'(rateGain) * 16'(rateOffCode) * 16'(st_r.initFullCap))
                         >> `CRTAC_OFF_SHIFT);
  assign reductionDiff = reductionTerm - 64'(offsetThr);

  always_comb begin
    // A heavy load saturates rather than wraps, so reported charge never jumps up.
    if (reductionTerm <= 64'(offsetThr)) begin
      reductionNow = 16'h0000;
    end else if (reductionDiff > 64'h0000_0000_0000_ffff) begin
      reductionNow = 16'hffff;
    end else begin
      reductionNow = reductionDiff[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Warning threshold numerator and divider step

  logic [14:0] thrFactor;
  logic [47:0] dropNum;
  logic [8:0] divRem9;
  logic divGe;
  logic [8:0] divRemSub;
  logic [7:0] divRemNext;
  logic [47:0] divNumNext;
  logic [47:0] dropMv;
  logic [12:0] warnMv;
  logic [12:0] emptyMv;
  logic [12:0] floorMv;
  logic [12:0] cedvMv;
  logic [12:0] effWarnMv;

  // The drop is divided by the initial capacity byte, which stands for one C; the
  // final shift by 15 removes the C scale of 256 and the cold unity of 128.
  assign thrFactor = 15'(thresholdColdGain) * 15'(coldDeg) + `CRTAC_THR_UNITY;
  assign dropNum = `CRTAC_MV_PER_COUNT * 48'(thresholdRateGain) *
                   48'(measIn.averageCurrent) * 48'(thrFactor);

  // Serial restoring division by the initial capacity byte keeps area small;
  // a zero divisor yields an all-ones quotient, so the floor then applies.
  assign divRem9 = {st_r.divRem, st_r.divNum[47]};
  assign divGe = divRem9 >= {1'b0, st_r.initFullCap};
  assign divRemSub = divRem9 - {1'b0, st_r.initFullCap};
  assign divRemNext = divGe ? divRemSub[7:0] : divRem9[7:0];
  assign divNumNext = {st_r.divNum[46:0], divGe};

  assign dropMv = divNumNext >> `CRTAC_DROP_SHIFT;
  assign warnMv = ({5'h00, st_r.warnScaled} + `CRTAC_SCALE_BIAS) << `CRTAC_MV_SHIFT;
  assign emptyMv = ({5'h00, st_r.emptyScaled} + `CRTAC_SCALE_BIAS) << `CRTAC_MV_SHIFT;
  assign floorMv = emptyMv + `CRTAC_EMPTY_MARGIN;
  assign cedvMv = (dropMv > 48'(warnMv)) ? 13'h0000 : 13'(48'(warnMv) - dropMv);
  assign effWarnMv = (cedvMv > floorMv) ? cedvMv : floorMv;

  //////////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic apbSetup;
  logic apbDone;
  logic [7:0] apbIdx;
  logic [31:0] readData;
  logic [15:0] availNow;
  logic [15:0] fullNow;

  assign apbSetup = psel && !penable;
  assign apbDone = psel && penable && st_r.pready;
  assign apbIdx = paddr[9:2];
  // Learned capacity is read at the end of the pass, so a write in mid-pass still counts.
  assign availNow = (st_r.meas.nominalAvailableCharge > st_r.reductionPend) ?
                    st_r.meas.nominalAvailableCharge - st_r.reductionPend : 16'h0000;
  assign fullNow = (st_r.learnedCap > st_r.reductionPend) ?
                   st_r.learnedCap - st_r.reductionPend : 16'h0000;

  always_comb begin
    readData = 32'h0000_0000;
    case (apbIdx)
      `CRTAC_IDX_INIT_FULL_CAP: readData = {24'h000000, st_r.initFullCap};
      `CRTAC_IDX_EMPTY_SCALED: readData = {24'h000000, st_r.emptyScaled};
      `CRTAC_IDX_WARN_SCALED: readData = {24'h000000, st_r.warnScaled};
      `CRTAC_IDX_THR_COLD_GAIN: readData = {24'h000000, st_r.thrColdReg};
      `CRTAC_IDX_PACK_CONFIG: readData = {24'h000000, st_r.packConfig};
      `CRTAC_IDX_AGE_THR: readData = {24'h000000, st_r.ageThrReg};
      `CRTAC_IDX_RATE_COEFFS: readData = {24'h000000, st_r.rateStored};
      `CRTAC_IDX_COLD_COEFFS: readData = {24'h000000, st_r.coldStored};
      `CRTAC_IDX_UPD_RATE: readData = {24'h000000, st_r.rateHost};
      `CRTAC_IDX_UPD_COLD: readData = {24'h000000, st_r.coldHost};
      `CRTAC_IDX_LEARNED_CAP: readData = {16'h0000, st_r.learnedCap};
      `CRTAC_IDX_STATUS: readData = {27'h0000000, st_r.fsm != CRTAC_IDLE, st_r.nacToFull,
                                     st_r.coldHostOvr, st_r.rateHostOvr,
                                     st_r.fullResetPend};
      `CRTAC_IDX_AVAIL: readData = {16'h0000, st_r.res.availCharge};
      `CRTAC_IDX_FULL: readData = {16'h0000, st_r.res.fullCapacity};
      `CRTAC_IDX_WARN: readData = {16'h0000, st_r.res.warnThresholdMv};
      `CRTAC_IDX_REDUCTION: readData = {16'h0000, st_r.res.reduction};
      default: readData = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.resultValid = 1'b0;
    st_nxt.nacToFull = minimumTaperDetect && !coldBelow;

    // A full reset restores learned capacity and drops host coefficient overrides.
    // A full-reset write in the same cycle sets the request again, so it is not lost.
    if (st_r.fullResetPend) begin
      st_nxt.learnedCap = {st_r.initFullCap, 8'h00};
      st_nxt.rateHostOvr = 1'b0;
      st_nxt.coldHostOvr = 1'b0;
      st_nxt.fullResetPend = 1'b0;
    end

    // Zero-wait APB: read data and error are prepared in the setup cycle.
    if (apbSetup) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !isMapped(paddr);
      st_nxt.prdata = isMapped(paddr) ? readData : 32'h0000_0000;
    end else if (apbDone) begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      // Writes land only in the access cycle, when the whole request is known to stand.
      if (pwrite && isMapped(paddr)) begin
        case (apbIdx)
          `CRTAC_IDX_INIT_FULL_CAP: st_nxt.initFullCap = pwdata[7:0];
          `CRTAC_IDX_EMPTY_SCALED: st_nxt.emptyScaled = pwdata[7:0];
          `CRTAC_IDX_WARN_SCALED: st_nxt.warnScaled = pwdata[7:0];
          `CRTAC_IDX_THR_COLD_GAIN: st_nxt.thrColdReg = pwdata[7:0];
          `CRTAC_IDX_PACK_CONFIG: st_nxt.packConfig = pwdata[7:0];
          `CRTAC_IDX_AGE_THR: st_nxt.ageThrReg = pwdata[7:0];
          `CRTAC_IDX_RATE_COEFFS: st_nxt.rateStored = pwdata[7:0];
          `CRTAC_IDX_COLD_COEFFS: st_nxt.coldStored = pwdata[7:0];
          `CRTAC_IDX_UPD_RATE: begin
            st_nxt.rateHost = pwdata[7:0];
            st_nxt.rateHostOvr = 1'b1;
          end
          `CRTAC_IDX_UPD_COLD: begin
            st_nxt.coldHost = pwdata[7:0];
            st_nxt.coldHostOvr = 1'b1;
          end
          `CRTAC_IDX_LEARNED_CAP: st_nxt.learnedCap = pwdata[15:0];
          `CRTAC_IDX_FULL_RESET: begin
            if (pwdata[0]) begin
              st_nxt.fullResetPend = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Updates that arrive during a pass are dropped; the next one is taken.
    case (st_r.fsm)
      CRTAC_IDLE: begin
        if (measUpdate) begin
          st_nxt.meas = measIn;
          st_nxt.reductionPend = reductionNow;
          st_nxt.divNum = dropNum;
          st_nxt.divRem = 8'h00;
          st_nxt.divCnt = `CRTAC_DIV_LAST;
          st_nxt.fsm = CRTAC_DIVIDE;
        end
      end
      CRTAC_DIVIDE: begin
        st_nxt.divNum = divNumNext;
        st_nxt.divRem = divRemNext;
        st_nxt.divCnt = st_r.divCnt - 6'h01;
        // The quotient is complete on this step, so the threshold uses its next value.
        if (st_r.divCnt == 6'h00) begin
          st_nxt.res.availCharge = availNow;
          st_nxt.res.fullCapacity = fullNow;
          st_nxt.res.reduction = st_r.reductionPend;
          st_nxt.res.warnThresholdMv = {3'h0, effWarnMv};
          st_nxt.resultValid = 1'b1;
          st_nxt.fsm = CRTAC_IDLE;
        end
      end
      default: st_nxt.fsm = CRTAC_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // State register

  // Configuration bytes clear on reset; the pending full reset then loads the learned
  // capacity from the initial capacity byte at the first edge after release.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.fsm <= CRTAC_IDLE;
      st_r.initFullCap <= `CRTAC_RST_BYTE;
      st_r.emptyScaled <= `CRTAC_RST_BYTE;
      st_r.warnScaled <= `CRTAC_RST_BYTE;
      st_r.thrColdReg <= `CRTAC_RST_BYTE;
      st_r.packConfig <= `CRTAC_RST_BYTE;
      st_r.ageThrReg <= `CRTAC_RST_BYTE;
      st_r.rateStored <= `CRTAC_RST_BYTE;
      st_r.coldStored <= `CRTAC_RST_BYTE;
      st_r.learnedCap <= `CRTAC_RST_LEARNED;
      st_r.fullResetPend <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Outputs are taken from the state register, so the bus and the core see no glitches.
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign results = st_r.res;
  assign resultValid = st_r.resultValid;
  assign learnedFullCapacity = st_r.learnedCap;
  assign nacToFullAllowed = st_r.nacToFull;
  assign busy = st_r.fsm != CRTAC_IDLE;

endmodule // crtac_comp

`default_nettype wire

// ---- verif/crtac_comp_properties.sv ----
// Purpose: Port-level checks of the compensation block.
// Assumes: Bound to crtac_comp; a single clock domain.
// Notes:   Expected figures follow the hand-over timing of one pass.
`timescale 1ns/100ps
`default_nettype none
module crtac_comp_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Measurements and results
  input wire logic measUpdate,
  input wire logic minimumTaperDetect,
  input wire crtac_pkg::crtac_result_type results,
  input wire logic resultValid,
  input wire logic [15:0] learnedFullCapacity,
  input wire logic nacToFullAllowed,
  input wire logic busy
);
  import crtac_pkg::*;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////
  sequence s_take;
    measUpdate && !busy;
  endsequence
  sequence s_run;
    busy [*8];
  endsequence

  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_error_read: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  a_pass_time: assert property (s_take |-> ##49 resultValid)
    else $error("pass latency wrong");
  a_busy_span: assert property (s_take |=> s_run)
    else $error("busy not held");
  a_valid_end: assert property (resultValid |-> !busy && $past(busy))
    else $error("result without pass");
  a_hold_res: assert property (!resultValid |-> $stable(results))
    else $error("results moved");
  // Full capacity must track the learned value seen at the end of the pass.
  a_full_calc: assert property (resultValid |-> results.fullCapacity ==
    ((learnedFullCapacity > results.reduction) ? learnedFullCapacity - results.reduction : 16'h0))
    else $error("full capacity wrong");
  a_warn_floor: assert property (resultValid |-> results.warnThresholdMv >= 16'h0820)
    else $error("warning below floor");
  a_taper_gate: assert property (!minimumTaperDetect |=> !nacToFullAllowed)
    else $error("taper gate open");
endmodule // crtac_comp_properties
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the compensation block.
// Assumes: Bench is APB master and measurement source.
// Notes:   Random inputs are kept small so products stay in range.
`timescale 1ns/100ps
`default_nettype none
`include "crtac_map.svh"
module testbench;
  import crtac_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic measUpdate = 1'b0;
  crtac_meas_type measIn = '0;
  logic taper = 1'b0;
  crtac_result_type results;
  logic resultValid;
  logic [15:0] learned;
  logic nacOk;
  logic busy;
  int failures = 0;
  int tests_run = 0;
  logic [7:0] cidx [8] = '{8'h76, 8'h77, 8'h78, 8'h79, 8'h7c, 8'h7d, 8'h7e, 8'h7f};
  logic [7:0] cfg [8];
  logic [7:0] rHost = 8'h00;
  logic [7:0] cHost = 8'h00;
  logic rOvr = 1'b0;
  logic cOvr = 1'b0;
  logic [31:0] rdv;
  logic err;

  always #20 core_clk = ~core_clk;

  crtac_comp dut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .measUpdate(measUpdate), .measIn(measIn), .minimumTaperDetect(taper),
    .results(results), .resultValid(resultValid), .learnedFullCapacity(learned),
    .nacToFullAllowed(nacOk), .busy(busy)
  );

  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] rbyte();
    return rOvr ? rHost : (cfg[4][1] ? 8'h6c : cfg[6]);
  endfunction
  function automatic logic [7:0] cbyte();
    return cOvr ? cHost : (cfg[4][0] ? 8'h46 : cfg[7]);
  endfunction
  function automatic logic [11:0] thr(input logic [7:0] c);
    return 12'(273 + 2 * c[2:0]);
  endfunction

  function automatic crtac_result_type model(input crtac_meas_type m, input logic [15:0] learned_full_capacity);
    logic [7:0] rb;
    logic [7:0] cb;
    longint unsigned d, aged, term, off, red, drop, compensated_warn_threshold, flr;
    crtac_result_type r;
    rb = rbyte();
    cb = cbyte();
    d = thr(cb) > m.tempKelvin ? thr(cb) - m.tempKelvin : 0;
    aged = rb[7:3] * (512 + cb[7:3] * m.totalCycleCount * cfg[5][7:6]);
    term = (m.averageCurrent * aged * (32 + cb[7:3] * d)) >> 22;
    off = (rb[7:3] * rb[2:0] * cfg[0]) >> 3;
    red = term <= off ? 0 : (term - off > 'hffff ? 'hffff : term - off);
    r.reduction = 16'(red);
    r.availCharge = 16'(m.nominalAvailableCharge > red ? m.nominalAvailableCharge - red : 0);
    r.fullCapacity = 16'(learned_full_capacity > red ? learned_full_capacity - red : 0);
    drop = ((8 * cfg[5][5:0] * m.averageCurrent * (128 + cfg[3][3:0] * d)) / cfg[0]) >> 15;
    compensated_warn_threshold = (cfg[2] + 256) * 8 > drop ? (cfg[2] + 256) * 8 - drop : 0;
    flr = (cfg[1] + 256) * 8 + 32;
    r.warnThresholdMv = 16'(compensated_warn_threshold > flr ? compensated_warn_threshold : flr);
    return r;
  endfunction

  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdv, exp);
  endtask

  // An accepted update in mid-pass would restart the count and show as extra latency.
  task automatic pass(input crtac_meas_type m, input logic [15:0] learned_full_capacity, input logic poke);
    int n;
    crtac_result_type e;
    e = model(m, learned_full_capacity);
    @(posedge core_clk);
    measIn <= m;
    measUpdate <= 1'b1;
    @(posedge core_clk);
    measUpdate <= 1'b0;
    n = 0;
    while (resultValid !== 1'b1 && n < 80) begin
      @(posedge core_clk);
      n++;
      measUpdate <= poke && n == 10;
    end
    chk(32'(n), 32'd49);
    chk({results.availCharge, results.fullCapacity}, {e.availCharge, e.fullCapacity});
    chk({results.warnThresholdMv, results.reduction}, {e.warnThresholdMv, e.reduction});
  endtask

  // The limit is far above the roughly 730 cycles the sequence needs.
  initial begin
    #2000000;
    failures++;
    print_verdict();
  end

  initial begin
    crtac_meas_type m;
    logic [15:0] lmdW;
    void'($urandom(97802));
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(cidx[i], 32'h0);
    end
    rd(`CRTAC_IDX_LEARNED_CAP, 32'h0);
    rd(8'h7a, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int k = 0; k < 8; k++) begin
      foreach (cfg[i]) begin
        cfg[i] = 8'($urandom);
      end
      cfg[0] = 8'($urandom_range(255, 1));
      cfg[4][1:0] = 2'(k);
      if (k == 0) begin
        cfg[5][7:6] = 2'b00;
      end
      for (int i = 0; i < 8; i++) begin
        apb(1'b1, cidx[i], {24'h0, cfg[i]});
      end
      if (k == 4) begin
        rOvr = 1'b1;
        rHost = 8'($urandom);
        apb(1'b1, `CRTAC_IDX_UPD_RATE, {24'h0, rHost});
      end
      if (k == 5) begin
        cOvr = 1'b1;
        cHost = 8'($urandom);
        apb(1'b1, `CRTAC_IDX_UPD_COLD, {24'h0, cHost});
      end
      lmdW = 16'($urandom);
      apb(1'b1, `CRTAC_IDX_LEARNED_CAP, {16'h0, lmdW});
      rd(8'h7e, {24'h0, cfg[6]});
      m.averageCurrent = k == 7 ? 16'h0 : 16'($urandom_range(4095, 0));
      m.tempKelvin = 12'($urandom_range(330, 250));
      if (k == 3) begin
        m.tempKelvin = thr(cbyte());
      end
      if (k == 6) begin
        m.tempKelvin = thr(cbyte()) - 12'h1;
      end
      m.totalCycleCount = 16'($urandom_range(1023, 0));
      m.nominalAvailableCharge = 16'($urandom);
      pass(m, lmdW, k[0]);
      taper <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk({31'h0, nacOk}, {31'h0, m.tempKelvin >= thr(cbyte())});
      taper <= 1'b0;
    end
    apb(1'b1, `CRTAC_IDX_FULL_RESET, 32'h1);
    repeat (2) @(posedge core_clk);
    rd(`CRTAC_IDX_LEARNED_CAP, {16'h0, cfg[0], 8'h00});
    chk({16'h0, learned}, {16'h0, cfg[0], 8'h00});
    rd(`CRTAC_IDX_STATUS, 32'h0);
    print_verdict();
  end
endmodule // testbench

bind crtac_comp crtac_comp_properties u_props (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .measUpdate(measUpdate),
  .minimumTaperDetect(minimumTaperDetect), .results(results), .resultValid(resultValid),
  .learnedFullCapacity(learnedFullCapacity), .nacToFullAllowed(nacToFullAllowed), .busy(busy)
);
`default_nettype wire
